/* File: design/dab_consts.svh */
// port addresses, field positions and reset values of the bus-side register slice
`ifndef DAB_CONSTS_SVH
`define DAB_CONSTS_SVH

`define DAB_ADDR_W 10
`define DAB_PORT_MISC 10'h3c2
`define DAB_PORT_ISR0 10'h3c2
`define DAB_PORT_CRT_IDX_MONO 10'h3b4
`define DAB_PORT_CRT_IDX_COLR 10'h3d4
`define DAB_PORT_CRT_DAT_MONO 10'h3b5
`define DAB_PORT_CRT_DAT_COLR 10'h3d5
`define DAB_PORT_STAT_MONO 10'h3ba
`define DAB_PORT_STAT_COLR 10'h3da
`define DAB_PORT_PEN_SET_COLR 10'h3dc
`define DAB_PORT_PEN_CLR_COLR 10'h3db
`define DAB_PORT_PEN_SET_MONO 10'h3b9
`define DAB_PORT_PEN_CLR_MONO 10'h3bb
`define DAB_SPACE_LO 10'h3b0
`define DAB_SPACE_HI 10'h3df

`define DAB_EMU_INDEX 8'hff

`define DAB_EMU_COLR_BIT 0
`define DAB_EMU_MONO_BIT 1
`define DAB_EMU_ACTIVE_BIT 2
`define DAB_EMU_TYPE_BIT 4
`define DAB_MISC_ADDR_SEL_BIT 0
`define DAB_MISC_CLK_LO_BIT 2
`define DAB_MISC_CLK_HI_BIT 3
`define DAB_MISC_VID_DIS_BIT 4

`define DAB_RST_FEATURE 2'h0
`define DAB_RST_EMU 3'h0
`define DAB_RST_EMU_TYPE 1'h0
`define DAB_RST_MISC 4'h0
`define DAB_RST_INDEX 8'h00

`endif

/* File: design/dab_pkg.sv */
// types shared by the display adapter bus-side register slice
package dab_pkg;

  typedef enum logic [1:0] {
    DAB_NATIVE = 2'b00,
    DAB_COLOUR = 2'b01,
    DAB_MONO = 2'b10
  } dab_mode_t;

  typedef struct packed {
    logic hsync_in_pin;
    logic vertical_in_pin;
    logic blue_video_in_pin;
  } dab_video_in_t;

  typedef struct packed {
    logic pen_switch;
    logic switch_sense;
    logic feature_code_in_a;
    logic feature_code_in_b;
  } dab_sense_in_t;

endpackage

/* File: design/dab_pen_latch.sv */
// light-pen latch: set by pen pulse or software, cleared by software only
`timescale 1ns/1ps
`include "dab_consts.svh"

module dab_pen_latch
  import dab_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pen_pulse_in,
  input wire logic sw_set,
  input wire logic sw_clear,
  output logic latch_q
);

  logic pen_prev_q;
  logic pen_fall;
  logic latch_d;

  // a valid pulse is the falling edge; inputs are already synchronous
  assign pen_fall = pen_prev_q & ~pen_pulse_in;
  // set wins over a clear landing in the same cycle
  assign latch_d = pen_fall | sw_set | (latch_q & ~sw_clear);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pen_prev_q <= 1'b1;
      latch_q <= 1'b0;
    end else begin
      pen_prev_q <= pen_pulse_in;
      latch_q <= latch_d;
    end
  end

  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (rst);

  pen_edge_set_a: assert property (pen_fall |=> latch_q)
    else $error("pen pulse edge did not set latch");
  pen_only_sw_clears_a: assert property (latch_q && !sw_clear |=> latch_q)
    else $error("pen latch dropped without a software clear");

endmodule

/* File: design/dab_regs.sv */
// bus-side register slice: feature, emulation and misc copies, status bits, light pen
//
// Behaviour
// - feature copy write-only, two bits, reset zero
// - feature bits drive the two feature pins
// - reads of controller-held registers pass local bus
// - emulation register via CRT data, index FFh
// - emulation bit 0 enables colour emulation
// - emulation bit 1 enables monochrome emulation
// - bit 2 marks emulation active; software keeps it
// - type bit 4 picks colour or monochrome
// - pen ports and status format follow mode
// - misc copy at 3C2h, bits 0,2,3,4
// - misc bit 0 moves CRT and status ports
// - misc bits 2,3 drive clock-select pins
// - misc bit 4 drives internal video disable
// - status 0 native: device drives all but bit 7
// - status 0 bits 4-6: switch, feature codes
// - status 1 port depends on mode
// - native status 1: bits 1,2 driven, 6,7 high
// - colour status 1: bits 1-3 driven, 4-7 high
// - mono status 1: bits 0,3,7 driven, rest high
// - mono status 1 bit 0 is hsync input
// - native and colour status 1: bit 1 latch, bit 2 pen switch
// - status 1 bit 3: inverted vertical or blue
// - latch set by pen pulse or software set
// - colour mode set port triggers on read too
`timescale 1ns/1ps
`include "dab_consts.svh"

module dab_regs
  import dab_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`DAB_ADDR_W-1:0] host_addr,
  input wire logic host_ior_n,
  input wire logic host_iow_n,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  input wire logic [7:0] local_data_in,
  input wire dab_video_in_t video_in,
  input wire dab_sense_in_t sense_in,
  input wire logic pen_pulse_in,
  output logic feature_out_a,
  output logic feature_out_b,
  output logic clock_choice_a,
  output logic clock_choice_b,
  output logic internal_video_disable_pin,
  output logic pen_latch_state,
  output dab_mode_t emu_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [1:0] feature_q;
  logic [2:0] emu_q;
  logic emu_type_q;
  logic [3:0] misc_q;
  logic [7:0] crt_index_q;
  logic iow_prev_q;
  logic ior_prev_q;
  logic [7:0] rd_data_q;
  logic rd_oe_q;
  dab_mode_t mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // strobes: one action per bus cycle, taken at the leading edge

  wire wr_go = iow_prev_q & ~host_iow_n;
  wire rd_go = ior_prev_q & ~host_ior_n;
  wire rd_act = ~host_ior_n;
  wire addr_sel = misc_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // mode from the emulation bits

  wire emu_on = emu_q[`DAB_EMU_ACTIVE_BIT];
  wire colour_mode = emu_on & emu_q[`DAB_EMU_COLR_BIT] & ~emu_type_q;
  wire mono_mode = emu_on & emu_q[`DAB_EMU_MONO_BIT] & emu_type_q;
  dab_mode_t mode_d;
  assign mode_d = colour_mode ? DAB_COLOUR : (mono_mode ? DAB_MONO : DAB_NATIVE);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire [`DAB_ADDR_W-1:0] crt_idx_port =
    addr_sel ? `DAB_PORT_CRT_IDX_COLR : `DAB_PORT_CRT_IDX_MONO;
  wire [`DAB_ADDR_W-1:0] crt_dat_port =
    addr_sel ? `DAB_PORT_CRT_DAT_COLR : `DAB_PORT_CRT_DAT_MONO;
  wire [`DAB_ADDR_W-1:0] stat_sel_port =
    addr_sel ? `DAB_PORT_STAT_COLR : `DAB_PORT_STAT_MONO;

  wire hit_misc = host_addr == `DAB_PORT_MISC;
  wire hit_crt_idx = host_addr == crt_idx_port;
  wire hit_crt_dat = host_addr == crt_dat_port;
  wire hit_feature = host_addr == stat_sel_port;
  wire hit_stat_colr = host_addr == `DAB_PORT_STAT_COLR;
  wire hit_stat_mono = host_addr == `DAB_PORT_STAT_MONO;
  wire hit_space = (host_addr >= `DAB_SPACE_LO) && (host_addr <= `DAB_SPACE_HI);

  // status 1 moves with the mode
  logic hit_stat1;
  always_comb begin
    unique case (mode_q)
      DAB_NATIVE: hit_stat1 = hit_feature;
      DAB_COLOUR: hit_stat1 = hit_stat_colr;
      DAB_MONO: hit_stat1 = hit_stat_mono;
      default: hit_stat1 = 1'b0;
    endcase
  end

  // light-pen ports: monochrome uses its own pair
  wire pen_set_hit = (mode_q == DAB_MONO) ?
    (host_addr == `DAB_PORT_PEN_SET_MONO) : (host_addr == `DAB_PORT_PEN_SET_COLR);
  wire pen_clr_hit = (mode_q == DAB_MONO) ?
    (host_addr == `DAB_PORT_PEN_CLR_MONO) : (host_addr == `DAB_PORT_PEN_CLR_COLR);
  wire colour_rd = rd_go & (mode_q == DAB_COLOUR);
  wire pen_sw_set = pen_set_hit & (wr_go | colour_rd);
  wire pen_sw_clear = pen_clr_hit & (wr_go | colour_rd);

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  wire wr_feature = wr_go & hit_feature;
  wire wr_index = wr_go & hit_crt_idx;
  wire wr_emu = wr_go & hit_crt_dat & (crt_index_q == `DAB_EMU_INDEX);
  wire wr_misc = wr_go & hit_misc;

  wire [1:0] feature_d = wr_feature ? host_data_in[1:0] : feature_q;
  wire [2:0] emu_d = wr_emu ? host_data_in[2:0] : emu_q;
  wire emu_type_d = wr_emu ? host_data_in[`DAB_EMU_TYPE_BIT] : emu_type_q;
  wire [7:0] crt_index_d = wr_index ? host_data_in : crt_index_q;
  wire [3:0] misc_in = {host_data_in[`DAB_MISC_VID_DIS_BIT], host_data_in[`DAB_MISC_CLK_HI_BIT],
    host_data_in[`DAB_MISC_CLK_LO_BIT], host_data_in[`DAB_MISC_ADDR_SEL_BIT]};
  wire [3:0] misc_d = wr_misc ? misc_in : misc_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      feature_q <= `DAB_RST_FEATURE;
      emu_q <= `DAB_RST_EMU;
      emu_type_q <= `DAB_RST_EMU_TYPE;
      misc_q <= `DAB_RST_MISC;
      crt_index_q <= `DAB_RST_INDEX;
    end else begin
      feature_q <= feature_d;
      emu_q <= emu_d;
      emu_type_q <= emu_type_d;
      misc_q <= misc_d;
      crt_index_q <= crt_index_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data: own bits merged over the local bus

  wire pen_latch;
  wire [7:0] isr0_native = {local_data_in[7], sense_in.feature_code_in_b,
    sense_in.feature_code_in_a, sense_in.switch_sense, 4'h0};
  wire [7:0] isr1_native = {2'h3, local_data_in[5:3], sense_in.pen_switch, pen_latch,
    local_data_in[0]};
  wire [7:0] isr1_colour = {4'hf, ~video_in.vertical_in_pin, sense_in.pen_switch, pen_latch,
    local_data_in[0]};
  wire [7:0] isr1_mono = {video_in.vertical_in_pin, 3'h7, video_in.blue_video_in_pin, 2'h3,
    video_in.hsync_in_pin};

  // emulation modes leave status 0 undefined; the local bus is passed as is
  logic [7:0] rd_data_d;
  always_comb begin
    rd_data_d = local_data_in;
    if (hit_stat1) begin
      unique case (mode_q)
        DAB_NATIVE: rd_data_d = isr1_native;
        DAB_COLOUR: rd_data_d = isr1_colour;
        DAB_MONO: rd_data_d = isr1_mono;
        default: rd_data_d = local_data_in;
      endcase
    end else if (hit_misc && mode_q == DAB_NATIVE) begin
      rd_data_d = isr0_native;
    end
  end

  // host bus is driven only for reads inside the adapter's port window
  wire rd_oe_d = rd_act & hit_space;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      iow_prev_q <= 1'b1;
      ior_prev_q <= 1'b1;
      rd_data_q <= 8'h00;
      rd_oe_q <= 1'b0;
      mode_q <= DAB_NATIVE;
    end else begin
      iow_prev_q <= host_iow_n;
      ior_prev_q <= host_ior_n;
      rd_data_q <= rd_data_d;
      rd_oe_q <= rd_oe_d;
      mode_q <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // light-pen latch

  dab_pen_latch u_pen (
    .sys_clk(sys_clk),
    .rst(rst),
    .pen_pulse_in(pen_pulse_in),
    .sw_set(pen_sw_set),
    .sw_clear(pen_sw_clear),
    .latch_q(pen_latch)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  assign feature_out_a = feature_q[0];
  assign feature_out_b = feature_q[1];
  assign clock_choice_a = misc_q[1];
  assign clock_choice_b = misc_q[2];
  assign internal_video_disable_pin = misc_q[3];
  assign pen_latch_state = pen_latch;
  assign emu_mode = mode_q;
  assign host_data_out = rd_data_q;
  assign host_data_oe = rd_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking dcr @(posedge sys_clk); endclocking
  default disable iff (rst);

  feature_pin_write_a: assert property (
    wr_feature |=> feature_out_a == $past(host_data_in[0])
      && feature_out_b == $past(host_data_in[1]))
    else $error("feature pins do not follow written bits");

  emu_index_write_a: assert property (
    wr_go && hit_crt_dat && crt_index_q == `DAB_EMU_INDEX
      |=> emu_q == $past(host_data_in[2:0]))
    else $error("emulation bits not loaded at index ff");

  emu_other_index_a: assert property (
    wr_go && crt_index_q != `DAB_EMU_INDEX |=> $stable(emu_q))
    else $error("emulation bits changed at wrong index");

  misc_pins_write_a: assert property (
    wr_misc |=> clock_choice_a == $past(host_data_in[2])
      && clock_choice_b == $past(host_data_in[3])
      && internal_video_disable_pin == $past(host_data_in[4]))
    else $error("misc pins do not follow written bits");

  status0_native_a: assert property (
    rd_act && hit_misc && mode_q == DAB_NATIVE
      |=> host_data_oe && host_data_out[6:4] == $past({sense_in.feature_code_in_b,
        sense_in.feature_code_in_a, sense_in.switch_sense}))
    else $error("status 0 bits wrong in native mode");

  status1_colour_a: assert property (
    rd_act && hit_stat_colr && mode_q == DAB_COLOUR
      |=> host_data_out[7:3] == {4'hf, ~$past(video_in.vertical_in_pin)})
    else $error("colour status 1 bits wrong");

  status1_mono_a: assert property (
    rd_act && hit_stat_mono && mode_q == DAB_MONO
      |=> host_data_out[0] == $past(video_in.hsync_in_pin)
        && host_data_out[6:4] == 3'h7 && host_data_out[2:1] == 2'h3)
    else $error("mono status 1 bits wrong");

  pen_write_set_a: assert property (
    wr_go && pen_set_hit |=> pen_latch_state)
    else $error("software set did not set pen latch");

  pen_read_native_a: assert property (
    rd_go && pen_set_hit && mode_q == DAB_NATIVE && !pen_latch_state
      && $stable(pen_pulse_in) && pen_pulse_in |=> !pen_latch_state)
    else $error("read set pen latch outside colour mode");

  passthrough_read_a: assert property (
    rd_act && hit_crt_dat |=> host_data_out == $past(local_data_in))
    else $error("controller-held read not passed through");

  native_mode_a: assert property (
    !emu_q[2] |=> emu_mode == DAB_NATIVE)
    else $error("emulation mode without active bit");

  // reset checks must see the reset cycle itself, so they opt out of the default disable
  outputs_reset_a: assert property (disable iff (1'b0)
    rst |=> !feature_out_a && !feature_out_b && !clock_choice_a && !clock_choice_b
      && !internal_video_disable_pin && !pen_latch_state && !host_data_oe)
    else $error("outputs not cleared by reset");

  emu_reset_a: assert property (disable iff (1'b0)
    rst |=> emu_q == `DAB_RST_EMU && emu_mode == DAB_NATIVE && !addr_sel)
    else $error("emulation or address select not cleared by reset");

  feature_hold_a: assert property (
    !wr_feature |=> $stable({feature_out_b, feature_out_a}))
    else $error("feature pins moved without a feature write");

  misc_hold_a: assert property (
    !wr_misc |=> $stable(misc_q))
    else $error("misc copy moved without a misc write");

  index_hold_a: assert property (
    !wr_index |=> $stable(crt_index_q))
    else $error("index pointer moved without an index write");

  colour_mode_a: assert property (
    emu_q[`DAB_EMU_ACTIVE_BIT] && emu_q[`DAB_EMU_COLR_BIT] && !emu_type_q
      |=> emu_mode == DAB_COLOUR)
    else $error("colour emulation not entered");

  mono_mode_a: assert property (
    emu_q[`DAB_EMU_ACTIVE_BIT] && emu_q[`DAB_EMU_MONO_BIT] && emu_type_q
      |=> emu_mode == DAB_MONO)
    else $error("monochrome emulation not entered");

  status0_fixed_a: assert property (
    rd_act && hit_misc && mode_q == DAB_NATIVE
      |=> host_data_out[3:0] == 4'h0 && host_data_out[7] == $past(local_data_in[7]))
    else $error("status 0 own or passed bits wrong");

  status1_native_a: assert property (
    rd_act && hit_feature && mode_q == DAB_NATIVE
      |=> host_data_out[7:6] == 2'h3
        && host_data_out[2:1] == {$past(sense_in.pen_switch), $past(pen_latch)})
    else $error("native status 1 bits wrong");

  pen_status_colour_a: assert property (
    rd_act && hit_stat_colr && mode_q == DAB_COLOUR
      |=> host_data_out[2:1] == {$past(sense_in.pen_switch), $past(pen_latch)})
    else $error("colour status 1 pen bits wrong");

  stat_port_moves_a: assert property (
    rd_act && hit_stat_mono && mode_q == DAB_COLOUR
      |=> host_data_out == $past(local_data_in))
    else $error("mono status port answered in colour mode");

  pen_clear_write_a: assert property (
    wr_go && pen_clr_hit && pen_pulse_in |=> !pen_latch_state)
    else $error("software clear did not clear pen latch");

  read_idle_a: assert property (
    !rd_act |=> !host_data_oe)
    else $error("host bus driven outside a read");

endmodule

/* File: test/dab_local_model.sv */
// far-side model of the graphics controller driving the local data bus
`timescale 1ns/1ps

module dab_local_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_ior_n,
  output logic [7:0] local_data_in,
  output logic [7:0] held_val
);
  logic [7:0] val_q;
  logic [7:0] cnt_q;

  // a fresh register value for every read, held still while the read lasts
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      val_q <= 8'h5a;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      if (host_ior_n) begin
        val_q <= {val_q[6:0], val_q[7] ^ val_q[5] ^ val_q[4] ^ val_q[3]};
      end
    end
  end

  // released bus moves every cycle so a stale value never passes
  assign local_data_in = host_ior_n ? ~cnt_q : val_q;
  assign held_val = val_q;
endmodule

/* File: test/test_display_adapter_bus_side_registers.sv */
// self-checking bench for the bus-side register slice
`timescale 1ns/1ps
`include "dab_consts.svh"

module test_display_adapter_bus_side_registers;
  import dab_pkg::*;
  logic sys_clk, rst, host_ior_n, host_iow_n, host_data_oe, pen_pulse_in;
  logic [9:0] host_addr;
  logic [7:0] host_data_in, host_data_out, local_data_in, held_val, e_idx;
  dab_video_in_t video_in;
  dab_sense_in_t sense_in;
  logic feature_out_a, feature_out_b, clock_choice_a, clock_choice_b;
  logic internal_video_disable_pin, pen_latch_state;
  dab_mode_t emu_mode;
  int miscompares, comparisons;
  logic [1:0] e_feat;
  logic [3:0] e_misc;
  logic [2:0] e_emu;
  logic e_typ, e_latch;
  logic [9:0] ports [12] = '{10'h3ba, 10'h3da, 10'h3c2, 10'h3dc, 10'h3db, 10'h3b9,
    10'h3bb, 10'h3b4, 10'h3b5, 10'h3d4, 10'h3d5, 10'h2ba};
  logic [7:0] emu_vals [3] = '{8'h00, 8'h05, 8'h16};

  dab_regs u_dut (.sys_clk(sys_clk), .rst(rst), .host_addr(host_addr),
    .host_ior_n(host_ior_n), .host_iow_n(host_iow_n), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .local_data_in(local_data_in), .video_in(video_in), .sense_in(sense_in),
    .pen_pulse_in(pen_pulse_in), .feature_out_a(feature_out_a),
    .feature_out_b(feature_out_b), .clock_choice_a(clock_choice_a),
    .clock_choice_b(clock_choice_b), .internal_video_disable_pin(internal_video_disable_pin),
    .pen_latch_state(pen_latch_state), .emu_mode(emu_mode));

  dab_local_model u_far (.sys_clk(sys_clk), .rst(rst), .host_ior_n(host_ior_n),
    .local_data_in(local_data_in), .held_val(held_val));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic dab_mode_t mode_f();
    if (e_emu[2] && e_emu[0] && !e_typ) return DAB_COLOUR;
    if (e_emu[2] && e_emu[1] && e_typ) return DAB_MONO;
    return DAB_NATIVE;
  endfunction

  task automatic check_pins();
    check(8'({feature_out_b, feature_out_a}), 8'(e_feat), "feature pins");
    check(8'({clock_choice_b, clock_choice_a}), 8'(e_misc[2:1]), "clock pins");
    check(8'(internal_video_disable_pin), 8'(e_misc[3]), "video disable");
    check(8'(pen_latch_state), 8'(e_latch), "pen latch");
    check(8'(emu_mode), 8'(mode_f()), "mode");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic sel;
    logic mono;
    sel = e_misc[0];
    mono = mode_f() == DAB_MONO;
    @(negedge sys_clk);
    host_addr = a;
    host_data_in = d;
    host_iow_n = 1'b0;
    @(negedge sys_clk);
    host_iow_n = 1'b1;
    if (a == `DAB_PORT_MISC) e_misc = {d[4], d[3], d[2], d[0]};
    if (a == (sel ? `DAB_PORT_STAT_COLR : `DAB_PORT_STAT_MONO)) e_feat = d[1:0];
    if (a == (sel ? `DAB_PORT_CRT_DAT_COLR : `DAB_PORT_CRT_DAT_MONO) &&
        e_idx == `DAB_EMU_INDEX) begin
      e_emu = d[2:0];
      e_typ = d[4];
    end
    if (a == (sel ? `DAB_PORT_CRT_IDX_COLR : `DAB_PORT_CRT_IDX_MONO)) e_idx = d;
    if (a == (mono ? `DAB_PORT_PEN_CLR_MONO : `DAB_PORT_PEN_CLR_COLR)) e_latch = 1'b0;
    if (a == (mono ? `DAB_PORT_PEN_SET_MONO : `DAB_PORT_PEN_SET_COLR)) e_latch = 1'b1;
    repeat (2) @(negedge sys_clk);
    check_pins();
  endtask

  task automatic rd(input logic [9:0] a);
    logic [7:0] exp;
    logic sel;
    logic inwin;
    dab_mode_t m;
    @(negedge sys_clk);
    video_in = 3'($urandom);
    sense_in = 4'($urandom);
    host_addr = a;
    host_ior_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    m = mode_f();
    sel = e_misc[0];
    exp = held_val;
    if (a == `DAB_PORT_ISR0 && m == DAB_NATIVE) begin
      exp = {held_val[7], sense_in.feature_code_in_b, sense_in.feature_code_in_a,
        sense_in.switch_sense, 4'h0};
    end
    if (m == DAB_NATIVE && a == (sel ? `DAB_PORT_STAT_COLR : `DAB_PORT_STAT_MONO)) begin
      exp = {2'b11, held_val[5:3], sense_in.pen_switch, e_latch, held_val[0]};
    end
    if (m == DAB_COLOUR && a == `DAB_PORT_STAT_COLR) begin
      exp = {4'hf, ~video_in.vertical_in_pin, sense_in.pen_switch, e_latch, held_val[0]};
    end
    if (m == DAB_MONO && a == `DAB_PORT_STAT_MONO) begin
      exp = {video_in.vertical_in_pin, 3'b111, video_in.blue_video_in_pin, 2'b11,
        video_in.hsync_in_pin};
    end
    inwin = (a >= `DAB_SPACE_LO) && (a <= `DAB_SPACE_HI);
    check(8'(host_data_oe), 8'(inwin), "read enable");
    if (inwin) check(host_data_out, exp, "read data");
    if (m == DAB_COLOUR && a == `DAB_PORT_PEN_CLR_COLR) e_latch = 1'b0;
    if (m == DAB_COLOUR && a == `DAB_PORT_PEN_SET_COLR) e_latch = 1'b1;
    host_ior_n = 1'b1;
    @(negedge sys_clk);
    check(8'(host_data_oe), 8'h00, "read release");
    check_pins();
  endtask

  task automatic pen();
    @(negedge sys_clk);
    pen_pulse_in = 1'b0;
    repeat (2) @(negedge sys_clk);
    e_latch = 1'b1;
    pen_pulse_in = 1'b1;
    check_pins();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    results();
  end

  initial begin
    {rst, host_ior_n, host_iow_n, pen_pulse_in} = 4'hf;
    {host_addr, host_data_in, video_in, sense_in} = '0;
    {e_feat, e_misc, e_emu, e_typ, e_latch, e_idx} = '0;
    void'($urandom(32'hbad7));
    repeat (5) @(negedge sys_clk);
    check_pins();
    check({host_data_out}, 8'h00, "reset data");
    rst = 1'b0;
    $display("test reset done");
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 3; m++) begin
        wr(`DAB_PORT_MISC, {3'($urandom), 4'($urandom), 1'(s)});
        wr(s ? `DAB_PORT_CRT_IDX_COLR : `DAB_PORT_CRT_IDX_MONO, 8'hfe);
        wr(s ? `DAB_PORT_CRT_DAT_COLR : `DAB_PORT_CRT_DAT_MONO, 8'h05);
        wr(s ? `DAB_PORT_CRT_IDX_COLR : `DAB_PORT_CRT_IDX_MONO, `DAB_EMU_INDEX);
        wr(s ? `DAB_PORT_CRT_DAT_COLR : `DAB_PORT_CRT_DAT_MONO, emu_vals[m]);
        pen();
        foreach (ports[i]) rd(ports[i]);
        foreach (ports[i]) if (i < 7) wr(ports[i], 8'($urandom));
        foreach (ports[i]) if (i < 7) rd(ports[i]);
      end
    end
    $display("test modes done");
    // reset again in mid-run, from an emulation mode with pins set
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    {e_feat, e_misc, e_emu, e_typ, e_latch, e_idx} = '0;
    check_pins();
    check(8'(host_data_oe), 8'h00, "reset enable");
    rst = 1'b0;
    $display("test midreset done");
    for (int n = 0; n < 400; n++) begin
      if ($urandom_range(0, 1)) rd(ports[$urandom_range(0, 11)]);
      else wr(ports[$urandom_range(0, 11)], 8'($urandom));
      if ($urandom_range(0, 15) == 0) pen();
    end
    $display("test random done");
    results();
  end
endmodule
